//--- bench/iotb_periph.sv
/*
 Peripheral controller model on the transfer bus.
 Assumes active-high pins and the sequencer clock.
*/
`timescale 1ns/1ps
`default_nettype none
module iotb_periph
   import iotb_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire iotb_pkg::iotb_sel_t   sel_i,
   input  wire iotb_pkg::iotb_pulse_t pul_i,
   input  wire logic                  sync_i,
   input  wire logic [4:0]            en_i,
   input  wire logic [4:0]            gr_i,
   input  wire logic [7:0]            ctl_i,
   input  wire logic [17:0]           word_i,
   output logic      [17:0]           data_o,
   output logic                       rd_o,
   output logic                       skip_o,
   output logic      [5:0]            req_o
);
   import iotb_pkg::*;
   localparam logic [5:0] DEV = 6'h2A;
   wire logic me = sel_i.device_select_line == DEV;
   wire logic put = me && pul_i.second_io_pulse && ctl_i[6];
   initial {data_o, rd_o, skip_o, req_o} = '0;
   // Released lines flip so a stale word never reads as valid
   always @(posedge clk_i) begin
      data_o <= put ? word_i : ~data_o;
      rd_o <= put;
      skip_o <= me && pul_i.first_io_pulse && ctl_i[7];
      if (sync_i)
         req_o <= ctl_i[5:0] & {{2{en_i[4]}}, en_i[3:0]};
      else
         req_o <= req_o & ~{{2{gr_i[4]}}, gr_i[3:0]};
   end
endmodule
`default_nettype wire

//--- bench/testbench.sv
/*
 Self-checking bench for the transfer bus sequencer.
 Assumes the peripheral model and the default phase length.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import iotb_pkg::*;
   logic clk = 0, rst_n = 0, req = 0, a3 = 0, wr = 0, rr = 0, ckr = 0, pir = 0;
   logic [17:0] instr = '0, acc = '0, aa = '0, ab = '0, word = '0;
   logic [7:0] ctl = '0;
   logic [3:0] ra = '0;
   logic [31:0] wd = '0, rdata;
   logic hold, done, clr, ld, pci, ovf, oe, sync, run, cen, cgr, prd, psk, cgk, pig;
   logic [17:0] ldat, sum, bdo, pd;
   logic [3:0] pen, pgr;
   logic [5:0] rq;
   iotb_sel_t sel;
   iotb_pulse_t pul;
   iotb_chan_t kind;
   wire logic [17:0] bus = oe ? bdo : pd;
   int num_errors = 0, compares = 0, cyc = 0;
   iotb_sequencer iotb_sequencer_inst (
      .ref_clk_i(clk), .reset_n_i(rst_n), .iot_request_i(req), .time_state_three_i(req),
      .memory_input_register_i(instr), .accumulator_i(acc), .clock_request_i(ckr),
      .cpu_hold_o(hold), .transfer_done_o(done), .accumulator_clear_o(clr),
      .accumulator_load_o(ld), .accumulator_load_data_o(ldat), .pc_increment_o(pci),
      .clock_grant_o(cgk), .pi_grant_o(pig), .add_third_cycle_i(a3), .add_operand_a_i(aa),
      .add_operand_b_i(ab), .add_sum_o(sum), .add_overflow_o(ovf), .bus_data_i(bus),
      .bus_data_o(bdo), .bus_data_oe_o(oe), .read_request_i(prd), .skip_request_i(psk),
      .priority_level_request_i(rq[3:0]), .channel_request_i(rq[5]),
      .single_cycle_request_i(rq[4]), .pi_request_i(pir), .select_o(sel),
      .io_pulse_o(pul), .io_sync_o(sync), .io_run_o(run), .priority_chain_enable_o(pen),
      .priority_level_grant_o(pgr), .channel_chain_enable_o(cen), .channel_grant_o(cgr),
      .channel_kind_o(kind), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rr), .reg_rdata_o(rdata));
   iotb_periph iotb_periph_inst (
      .clk_i(clk), .sel_i(sel), .pul_i(pul), .sync_i(sync), .en_i({cen, pen}),
      .gr_i({cgr, pgr}), .ctl_i(ctl), .word_i(word), .data_o(pd), .rd_o(prd),
      .skip_o(psk), .req_o(rq));
   initial forever #2.5 clk = ~clk;
   task automatic summarize;
      $display("checks %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Ceiling sits well above the roughly 22k cycles of the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic rop(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= w;
      rr <= !w;
      @(posedge clk);
      wr <= 0;
      rr <= 0;
      @(negedge clk);
      if (!w)
         chk("reg read", d, rdata);
   endtask
   function automatic logic [17:0] ocs(logic [17:0] a, logic [17:0] b);
      logic [18:0] s;
      s = a + b;
      return s[17:0] + 18'(s[18]);
   endfunction
   task automatic xfer(int i);
      int n = 0, p1 = 0, p2 = 0, p4 = 0, nc = 0, nl = 0;
      logic [17:0] w;
      logic [3:0] k;
      logic me;
      w = 18'($urandom);
      w[MI_IOP1_BIT] = i[0];
      w[MI_IOP2_BIT] = i[1];
      w[MI_IOP4_BIT] = i[2];
      if (i[3])
         w[MI_DEV_MSB -: DEV_W] = 6'h2A;
      k = w[MI_CLR_BIT:MI_IOP1_BIT];
      me = w[MI_DEV_MSB -: DEV_W] == 6'h2A;
      @(negedge sync);
      @(posedge clk);
      req <= 1;
      instr <= w;
      acc <= 18'($urandom);
      word <= 18'($urandom);
      ctl <= 8'($urandom) & 8'hC0;
      @(negedge sync);
      do begin
         @(negedge clk);
         n++;
         if (n == 1) begin
            chk("select", {w[MI_DEV_MSB -: DEV_W], w[MI_SUB_MSB -: SUB_W]}, sel);
            chk("hold", 1, hold);
            if (!k[3])
               chk("bus data", acc, bdo);
         end
         p1 += pul.first_io_pulse === 1'b1;
         p2 += pul.second_io_pulse === 1'b1;
         p4 += pul.fourth_io_pulse === 1'b1;
         nc += clr === 1'b1;
         if (ld === 1'b1) begin
            nl++;
            chk("bus enable", !(me && ctl[6]), oe);
            if (me && ctl[6] || !k[3])
               chk("load data", me && ctl[6] ? word : acc, ldat);
         end
      end while (done !== 1'b1 && n < 600);
      chk("done time", 201 + (k[2] | k[1]) * 200 + k[2] * 100, n);
      chk("first width", k[0] * 150, p1);
      chk("second width", k[1] * 150, p2);
      chk("fourth width", k[2] * 100, p4);
      chk("clear", k[3], nc);
      chk("loads", k[1], nl);
      chk("skip", me && ctl[7] && k[0], pci);
      @(posedge clk);
      req <= 0;
   endtask
   initial begin
      logic [3:0] w;
      logic [17:0] s;
      void'($urandom(74751));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      @(negedge clk);
      chk("idle", 0, {pul, done, pgr, cgr});
      chk("enables", 6'h3F, {run, cen, pen});
      rop(0, REG_CTRL, 32'h3F);
      rop(0, 4'hC, 0);
      rop(0, REG_STATUS, 0);
      $display("test reset done");
      for (int i = 0; i < 16; i++)
         xfer(i);
      $display("test transfer done");
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         a3 <= i != 5;
         aa <= i ? 18'($urandom) : 18'h1FFFF;
         ab <= i ? 18'($urandom) : 18'h00001;
         @(posedge clk);
         @(negedge clk);
         s = ocs(aa, ab);
         if (a3)
            chk("sum", s, sum);
         chk("overflow", a3 && aa[17] == ab[17] && s[17] != aa[17], ovf);
      end
      a3 <= 0;
      $display("test adder done");
      rop(1, REG_CTRL, 32'h3E);
      chk("chain enable", 4'hE, pen);
      @(posedge clk);
      ctl <= 8'h01;
      w = 0;
      repeat (600) begin
         @(negedge clk);
         w |= pgr;
      end
      chk("masked grant", 0, w);
      rop(1, REG_CTRL, 32'h3F);
      for (int i = 0; i < 9; i++) begin
         w = i < 4 ? 4'h1 << i : 4'($urandom) | 4'h8;
         @(posedge clk);
         ctl <= i < 6 ? {4'h0, w} : 8'((i - 5) << 4);
         for (int k = 0; k < 1000 && pgr === 4'h0 && cgr !== 1'b1; k++)
            @(negedge clk);
         if (i < 6)
            chk("level grant", w & (~w + 4'h1), pgr);
         else
            chk("channel kind", i - 5, kind);
         @(posedge clk);
         ctl <= 0;
         repeat (600) @(posedge clk);
      end
      ckr <= 1;
      pir <= 1;
      ctl <= 8'h01;
      repeat (300) @(negedge clk);
      chk("clock first", 6'h20, {cgk, pgr, pig});
      @(posedge clk);
      ckr <= 0;
      ctl <= 0;
      repeat (600) @(negedge clk);
      chk("pi last", 6'h01, {cgk, pgr, pig});
      $display("test grants done");
      summarize();
   end
endmodule
`default_nettype wire

//--- include/iotb_pkg.sv
/*
 Shared constants, types and carriers of the I/O transfer bus sequencer.
 Assumes 18-bit words with bit 0 as the most significant bit.
*/
package iotb_pkg;
   localparam int WORD_W     = 18;
   localparam int DEV_W      = 6;
   localparam int SUB_W      = 2;
   localparam int API_LEVELS = 4;

   // Word bit n sits at vector index WORD_W-1-n
   localparam int MI_DEV_MSB   = WORD_W - 1 - 6;
   localparam int MI_SUB_MSB   = WORD_W - 1 - 12;
   localparam int MI_CLR_BIT   = WORD_W - 1 - 14;
   localparam int MI_IOP4_BIT  = WORD_W - 1 - 15;
   localparam int MI_IOP2_BIT  = WORD_W - 1 - 16;
   localparam int MI_IOP1_BIT  = WORD_W - 1 - 17;
   localparam int SIGN_BIT     = WORD_W - 1;

   // Timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int PHASE_NS       = 250;
   localparam int PHASE_CYC      = PHASE_NS / CLK_PERIOD_NS;
   localparam int PULSE_LONG_NS  = 750;
   localparam int PULSE_SHORT_NS = 500;
   localparam int PULSE_LONG_PH  = PULSE_LONG_NS / PHASE_NS;
   localparam int PULSE_SHORT_PH = PULSE_SHORT_NS / PHASE_NS;
   localparam logic [1:0] PH_SYNC = 2'h0;
   localparam logic [1:0] PH_LAST = 2'h3;

   // Request synchroniser slots, index 0 is highest priority
   localparam int SYN_DCH = 0;
   localparam int SYN_CLK = 1;
   localparam int SYN_API = 2;
   localparam int SYN_PI  = 3;
   localparam int SYN_IOT = 4;
   localparam int SYN_N   = 5;

   // Register port
   localparam int         REG_AW       = 4;
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_STATUS   = 4'h4;
   localparam logic [3:0] REG_ACC_IN   = 4'h8;
   localparam int         CTRL_W       = 6;
   localparam logic [5:0] CTRL_RESET   = 6'h3F;
   localparam int         CTRL_DCH_BIT = 4;
   localparam int         CTRL_RUN_BIT = 5;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_P1   = 2'b01,
      ST_P2   = 2'b10,
      ST_P4   = 2'b11
   } iotb_state_t;

   // Encoding is {channel_request, single_cycle_request}
   typedef enum logic [1:0] {
      CH_NONE   = 2'b00,
      CH_SC_OUT = 2'b01,
      CH_MULTI  = 2'b10,
      CH_SC_IN  = 2'b11
   } iotb_chan_t;

   typedef struct packed {
      logic [DEV_W-1:0] device_select_line;
      logic [SUB_W-1:0] subdevice_select_line;
   } iotb_sel_t;

   typedef struct packed {
      logic first_io_pulse;
      logic second_io_pulse;
      logic fourth_io_pulse;
   } iotb_pulse_t;
endpackage

//--- verilog/iotb_sequencer.sv
/*
 I/O processor side of the peripheral bus: phase timing, request
 synchronisation, transfer instruction pulse sequencing, chain grants.
 Assumes bus pins are converted to active-high levels at the pads and
 that the CPU drops its transfer request within one phase of done.
*/
`timescale 1ns/1ps
`default_nettype none
module iotb_sequencer
   import iotb_pkg::*;
#(
   parameter int PHASE_CYCLES = iotb_pkg::PHASE_CYC
) (
   input  wire logic                            ref_clk_i,
   input  wire logic                            reset_n_i,
   // CPU side, same clock
   input  wire logic                            iot_request_i,
   input  wire logic                            time_state_three_i,
   input  wire logic [iotb_pkg::WORD_W-1:0]     memory_input_register_i,
   input  wire logic [iotb_pkg::WORD_W-1:0]     accumulator_i,
   input  wire logic                            clock_request_i,
   output logic                                 cpu_hold_o,
   output logic                                 transfer_done_o,
   output logic                                 accumulator_clear_o,
   output logic                                 accumulator_load_o,
   output logic [iotb_pkg::WORD_W-1:0]          accumulator_load_data_o,
   output logic                                 pc_increment_o,
   output logic                                 clock_grant_o,
   output logic                                 pi_grant_o,
   // Data channel adder, same clock
   input  wire logic                            add_third_cycle_i,
   input  wire logic [iotb_pkg::WORD_W-1:0]     add_operand_a_i,
   input  wire logic [iotb_pkg::WORD_W-1:0]     add_operand_b_i,
   output logic [iotb_pkg::WORD_W-1:0]          add_sum_o,
   output logic                                 add_overflow_o,
   // Peripheral bus pins
   input  wire logic [iotb_pkg::WORD_W-1:0]     bus_data_i,
   output logic [iotb_pkg::WORD_W-1:0]          bus_data_o,
   output logic                                 bus_data_oe_o,
   input  wire logic                            read_request_i,
   input  wire logic                            skip_request_i,
   input  wire logic [iotb_pkg::API_LEVELS-1:0] priority_level_request_i,
   input  wire logic                            channel_request_i,
   input  wire logic                            single_cycle_request_i,
   input  wire logic                            pi_request_i,
   output iotb_pkg::iotb_sel_t                  select_o,
   output iotb_pkg::iotb_pulse_t                io_pulse_o,
   output logic                                 io_sync_o,
   output logic                                 io_run_o,
   output logic [iotb_pkg::API_LEVELS-1:0]      priority_chain_enable_o,
   output logic [iotb_pkg::API_LEVELS-1:0]      priority_level_grant_o,
   output logic                                 channel_chain_enable_o,
   output logic                                 channel_grant_o,
   output iotb_pkg::iotb_chan_t                 channel_kind_o,
   // Register port
   input  wire logic [iotb_pkg::REG_AW-1:0]     reg_addr_i,
   input  wire logic [31:0]                     reg_wdata_i,
   input  wire logic                            reg_wr_i,
   input  wire logic                            reg_rd_i,
   output logic [31:0]                          reg_rdata_o
);
   import iotb_pkg::*;

   localparam int PCW      = $clog2(PHASE_CYCLES);
   localparam int SYNC_W   = WORD_W + 5 + API_LEVELS;
   localparam int LONG_CYC = PULSE_LONG_PH * PHASE_CYCLES;
   localparam int SHRT_CYC = PULSE_SHORT_PH * PHASE_CYCLES;

   initial begin
      if (PHASE_CYCLES < 2) begin
         $error("iotb_sequencer: PHASE_CYCLES must be at least 2");
      end
   end

   // Pin inputs pass the synchroniser first
   logic [SYNC_W-1:0]     pins_s;
   logic [WORD_W-1:0]     data_s;
   logic                  rd_s;
   logic                  skip_s;
   logic [API_LEVELS-1:0] api_s;
   logic                  chan_s;
   logic                  sc_s;
   logic                  pi_s;

   iotb_sync2 #(
      .W (SYNC_W)
   ) u_pin_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({bus_data_i, read_request_i, skip_request_i,
                   priority_level_request_i, channel_request_i,
                   single_cycle_request_i, pi_request_i}),
      .sync_o    (pins_s)
   );

   assign {data_s, rd_s, skip_s, api_s, chan_s, sc_s, pi_s} = pins_s;

   // Phase generator
   logic [PCW-1:0] pcnt;
   logic [1:0]     ph;
   wire            ph_end = (pcnt == PCW'(PHASE_CYCLES - 1));
   wire            t4_end = ph_end && (ph == PH_LAST);
   wire            t1_end = ph_end && (ph == PH_SYNC);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pcnt <= '0;
         ph   <= PH_SYNC;
      end else begin
         pcnt <= ph_end ? '0 : pcnt + 1'b1;
         ph   <= ph_end ? ph + 2'h1 : ph;
      end
   end

   assign io_sync_o = (ph == PH_SYNC);

   // Control register
   logic [CTRL_W-1:0] ctrl;
   wire               run     = ctrl[CTRL_RUN_BIT];
   wire [API_LEVELS-1:0] api_en = ctrl[API_LEVELS-1:0] & {API_LEVELS{run}};

   assign io_run_o                = run;
   assign priority_chain_enable_o = api_en;
   assign channel_chain_enable_o  = ctrl[CTRL_DCH_BIT] && run;

   // Request synchroniser
   logic [SYN_N-1:0] stage1;
   logic [SYN_N-1:0] sync_q;
   iotb_state_t      state;
   iotb_state_t      next_state;
   wire [API_LEVELS-1:0] api_rq   = api_s & api_en;
   wire [API_LEVELS-1:0] api_pick = api_rq & (~api_rq + 1'b1);
   wire [SYN_N-1:0]  raw_req;
   wire [SYN_N-1:0]  pick     = stage1 & (~stage1 + 1'b1);
   wire              promote  = t1_end && !sync_q[SYN_IOT];
   wire              iot_go   = promote && pick[SYN_IOT];
   wire              done_now = (state != ST_IDLE) && (next_state == ST_IDLE);

   assign raw_req[SYN_DCH] = (chan_s || sc_s) && channel_chain_enable_o;
   assign raw_req[SYN_CLK] = clock_request_i;
   assign raw_req[SYN_API] = |api_rq;
   assign raw_req[SYN_PI]  = pi_s && run;
   assign raw_req[SYN_IOT] = iot_request_i && (state == ST_IDLE);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stage1 <= '0;
         sync_q <= '0;
      end else begin
         if (t4_end) begin
            stage1 <= raw_req;
         end else if (promote || done_now) begin
            stage1 <= '0;
         end
         if (promote) begin
            sync_q <= pick;
         end else if (done_now) begin
            sync_q <= '0;
         end
      end
   end

   // Grants and channel decode
   logic [API_LEVELS-1:0] api_grant;
   iotb_chan_t            chan_kind;
   wire iotb_chan_t       chan_dec = iotb_chan_t'({chan_s, sc_s});

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         api_grant <= '0;
         chan_kind <= CH_NONE;
      end else if (promote) begin
         api_grant <= pick[SYN_API] ? api_pick : '0;
         chan_kind <= pick[SYN_DCH] ? chan_dec : CH_NONE;
      end
   end

   assign priority_level_grant_o = api_grant;
   assign channel_grant_o        = sync_q[SYN_DCH];
   assign channel_kind_o         = chan_kind;
   assign clock_grant_o          = sync_q[SYN_CLK];
   assign pi_grant_o             = sync_q[SYN_PI];

   // Transfer instruction sequencer
   logic [1:0]        sp;
   logic [2:0]        op;
   logic [WORD_W-1:0] drv;
   iotb_sel_t         sel;
   logic              rd_hold;
   logic              skip_seen;
   wire               sp_last  = ph_end && (sp == 2'h3);
   wire               op_more  = op[MI_IOP2_BIT] || op[MI_IOP4_BIT];
   wire               in_long  = (sp < 2'(PULSE_LONG_PH));

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (iot_go) begin
               next_state = ST_P1;
            end
         end
         ST_P1: begin
            if (sp_last) begin
               next_state = op_more ? ST_P2 : ST_IDLE;
            end
         end
         ST_P2: begin
            if (sp_last) begin
               next_state = op[MI_IOP4_BIT] ? ST_P4 : ST_IDLE;
            end
         end
         ST_P4: begin
            if (ph_end && (sp == 2'(PULSE_SHORT_PH - 1))) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   assign io_pulse_o.first_io_pulse  = (state == ST_P1) && in_long
                                       && op[MI_IOP1_BIT];
   assign io_pulse_o.second_io_pulse = (state == ST_P2) && in_long
                                       && op[MI_IOP2_BIT];
   assign io_pulse_o.fourth_io_pulse = (state == ST_P4);

   // Accumulator leaves the data lines once the device claims them
   assign bus_data_oe_o = (state != ST_IDLE) && !((state == ST_P2)
                          && (rd_s || rd_hold));
   assign bus_data_o    = drv;
   assign select_o      = sel;
   assign cpu_hold_o    = time_state_three_i && iot_request_i
                          && !transfer_done_o;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state     <= ST_IDLE;
         sp        <= 2'h0;
         op        <= 3'h0;
         drv       <= '0;
         sel       <= '0;
         rd_hold   <= 1'b0;
         skip_seen <= 1'b0;
      end else begin
         state <= next_state;
         sp    <= (next_state != state) ? 2'h0 : sp + 2'(ph_end);
         if (iot_go) begin
            op  <= memory_input_register_i[MI_IOP1_BIT +: 3];
            sel <= memory_input_register_i[MI_DEV_MSB -: DEV_W + SUB_W];
            drv <= memory_input_register_i[MI_CLR_BIT] ? '0
                   : accumulator_i;
         end else if (done_now) begin
            sel <= '0;
            drv <= '0;
         end
         rd_hold   <= !done_now && (rd_hold
                      || (io_pulse_o.second_io_pulse && rd_s));
         skip_seen <= !iot_go && (skip_seen
                      || (io_pulse_o.first_io_pulse && skip_s));
      end
   end

   // CPU handshake strobes
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         transfer_done_o         <= 1'b0;
         accumulator_clear_o     <= 1'b0;
         accumulator_load_o      <= 1'b0;
         accumulator_load_data_o <= '0;
         pc_increment_o          <= 1'b0;
      end else begin
         transfer_done_o     <= done_now;
         accumulator_clear_o <= iot_go
                                && memory_input_register_i[MI_CLR_BIT];
         accumulator_load_o  <= (state == ST_P2) && op[MI_IOP2_BIT] && ph_end
                                && (sp == 2'(PULSE_LONG_PH - 1));
         if ((state == ST_P2) && ph_end && (sp == 2'(PULSE_LONG_PH - 1))) begin
            accumulator_load_data_o <= data_s;
         end
         pc_increment_o      <= done_now && skip_seen;
      end
   end

   // Add-to-memory overflow, end-around carry
   wire [WORD_W:0]   raw_sum = {1'b0, add_operand_a_i} + {1'b0, add_operand_b_i};
   wire [WORD_W-1:0] oc_sum  = raw_sum[WORD_W-1:0] + WORD_W'(raw_sum[WORD_W]);
   wire              ovf     = add_third_cycle_i
                               && (add_operand_a_i[SIGN_BIT] == add_operand_b_i[SIGN_BIT])
                               && (oc_sum[SIGN_BIT] != add_operand_a_i[SIGN_BIT]);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         add_sum_o      <= '0;
         add_overflow_o <= 1'b0;
      end else begin
         add_sum_o      <= oc_sum;
         add_overflow_o <= ovf;
      end
   end

   // Register port; unmapped reads return zero
   wire        wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
   wire [31:0] status  = {20'h0, rd_hold, add_overflow_o, skip_seen,
                          chan_kind, state, sync_q};
   wire [31:0] rd_mux  = (reg_addr_i == REG_CTRL)   ? {26'h0, ctrl} :
                         (reg_addr_i == REG_STATUS) ? status :
                         (reg_addr_i == REG_ACC_IN) ? {14'h0, accumulator_load_data_o} :
                         32'h0;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl        <= CTRL_RESET;
         reg_rdata_o <= 32'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata_i[CTRL_W-1:0];
         end
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   // Checks
   logic [9:0] plen;
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         plen <= '0;
      end else begin
         plen <= (|io_pulse_o) ? plen + 10'h1 : 10'h0;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_iop1_width: assert property ($fell(io_pulse_o.first_io_pulse)
      |-> plen == 10'(LONG_CYC)) else $error("first pulse width wrong");
   a_iop2_width: assert property ($fell(io_pulse_o.second_io_pulse)
      |-> plen == 10'(LONG_CYC)) else $error("second pulse width wrong");
   a_iop4_width: assert property ($fell(io_pulse_o.fourth_io_pulse)
      |-> plen == 10'(SHRT_CYC) && transfer_done_o) else $error("fourth pulse wrong");
   a_done_early: assert property ($fell(io_pulse_o.first_io_pulse)
      && !op_more |-> ##[1:51] transfer_done_o) else $error("no done after first");
   a_acc_strobe: assert property ($rose(io_pulse_o.second_io_pulse)
      |-> ##150 accumulator_load_o) else $error("accumulator strobe mistimed");
   a_read_release: assert property (io_pulse_o.second_io_pulse
      && rd_s |-> !bus_data_oe_o) else $error("accumulator still on bus");
   a_clear_acc: assert property (iot_go
      && memory_input_register_i[MI_CLR_BIT] |=> accumulator_clear_o && drv == '0)
      else $error("accumulator clear missed");
   a_select_drive: assert property (iot_go |=> select_o
      == $past(memory_input_register_i[MI_DEV_MSB -: DEV_W + SUB_W]))
      else $error("select lines wrong");
   a_sync_period: assert property ($rose(io_sync_o)
      |-> ##200 $rose(io_sync_o)) else $error("sync period wrong");
   a_single_grant: assert property ($onehot0({api_grant,
      sync_q[SYN_DCH], state != ST_IDLE})) else $error("overlapping grants");
   a_add_overflow: assert property (ovf |=> add_overflow_o)
      else $error("overflow not flagged");
   a_cpu_hold: assert property (time_state_three_i && iot_request_i
      && state != ST_IDLE |-> cpu_hold_o) else $error("CPU not held");
endmodule
`default_nettype wire

//--- verilog/iotb_sync2.sv
/*
 Two flip-flop synchroniser for a vector of independent levels.
 Assumes each bit is a level; multi-bit words must be stable when sampled.
*/
`timescale 1ns/1ps
`default_nettype none
module iotb_sync2 #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         reset_n_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta;

   initial begin
      if (W < 1) begin
         $error("iotb_sync2: W must be at least 1");
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire
